/* File: hw/dsd_decoder.sv */
/*
  Data-space decoder and access sequencer: maps each data address onto its
  region, runs external SRAM strobes with wait states, updates pointers and
  hosts the CPU control location and the non-volatile store port.
  Assumes the CPU holds a request until it is taken and that external SRAM
  read data settles within the strobe, timed from this clock.
*/
//
// How it works
// - Normal map: 32 registers, 64 standard I/O, 160 extended I/O, 4096 SRAM.
// - Compatibility map drops extended I/O; 4000 SRAM bytes follow standard I/O.
// - Port in/out reaches only the 64 standard I/O locations.
// - Addresses above the internal region go to external SRAM.
// - External strobes stay inactive throughout internal accesses.
// - External SRAM works only while the enable bit is set.
// - Each external byte takes one cycle more with no wait states.
// - External stack push/pop of two bytes adds three cycles.
// - Wait states one to three add two/three/four, stack five/seven/nine.
// - Internal accesses finish in two cycles.
// - Displacement adds up to 63 to the Y or Z pointer.
// - Pre-decrement and post-increment write the new pointer back.
// - Non-volatile store is 4K bytes, 12-bit address.
// - Upper four address bits read as zero.
// - Non-volatile read halts the CPU four cycles.
// - Non-volatile write halts the CPU two cycles.
// - Writes are self-timed and expose a busy status bit.
// - Write starts only within four cycles of master enable.
// - Write strobe bit clears itself after the write time.
// - During a write, reads are blocked and address changes ignored.
//
`timescale 1ns/100ps
module dsd_decoder import dsd_pkg::*; #(
  parameter int NV_WRITE_CYC = NV_WRITE_CYCLES
) (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rst,
  // Configuration
  input  wire logic        compatMode,
  input  wire logic [1:0]  waitStates,
  // CPU access request
  input  wire logic        accReq,
  input  wire logic        accWrite,
  input  wire logic        accPortIo,
  input  wire logic        accStack,
  input  wire dsd_mode_e   accMode,
  input  wire logic [15:0] accAddr,
  input  wire logic [1:0]  accPtrSel,
  input  wire logic [15:0] accPtr,
  input  wire logic [5:0]  accDisp,
  input  wire logic [7:0]  accWdata,
  input  wire logic [7:0]  intRdata,
  // CPU answer
  output logic             accReady,
  output logic             accDone,
  output logic [7:0]       accRdata,
  output dsd_region_e      accRegion,
  output logic             cpuHalt,
  // Pointer write-back
  output logic             ptrWrEn,
  output logic [1:0]       ptrWrSel,
  output logic [15:0]      ptrWrData,
  // External SRAM
  output logic [15:0]      extAddr,
  output logic [7:0]       extWdata,
  output logic             extDataOe,
  input  wire logic [7:0]  extRdata,
  output logic             extWriteStrobeN,
  output logic             extReadStrobeN
);

  typedef enum logic {SEQ_IDLE, SEQ_BUSY} dsd_seq_e;

  dsd_seq_e    state_reg, state_next;
  logic [3:0]  cnt_reg, cnt_next;
  logic [3:0]  strobeLen_reg, strobeLen_next;
  logic        isExt_reg, isExt_next;
  logic        write_reg, write_next;
  logic        compat_reg, compat_next;
  logic [7:0]  cpuCtrl_reg, cpuCtrl_next;
  logic [5:0]  ioAddr_reg, ioAddr_next;
  logic        ioWr_reg, ioWr_next;
  logic [7:0]  ioWd_reg, ioWd_next;
  logic        accReady_next, accDone_next;
  logic [7:0]  accRdata_next;
  dsd_region_e accRegion_next;
  logic        ptrWrEn_next;
  logic [1:0]  ptrWrSel_next;
  logic [15:0] ptrWrData_next;
  logic [15:0] extAddr_next;
  logic [7:0]  extWdata_next;
  logic        extDataOe_next, extWrN_next, extRdN_next;
  logic [15:0] effAddr, ptrNew, ioOff;
  logic        ptrUpd, take, takeExt, extEn;
  logic [3:0]  extra;
  logic [7:0]  nvRdata, ioRdata;
  dsd_region_e takeRegion;

  // ----------------------------------------------------------------
  // Address generation and decode
  // ----------------------------------------------------------------
  always_comb begin
    effAddr = accAddr;
    ptrNew  = accPtr;
    ptrUpd  = 1'b0;
    unique case (accMode)
      AM_DIRECT:   effAddr = accAddr;
      AM_INDIRECT: effAddr = accPtr;
      // X has no displacement form, so its offset is forced to zero
      AM_DISP:     effAddr = accPtr + ((accPtrSel == PTR_X) ? 16'h0000 : {10'h000, accDisp});
      AM_PREDEC: begin
        effAddr = accPtr - 16'h0001;
        ptrNew  = accPtr - 16'h0001;
        ptrUpd  = 1'b1;
      end
      AM_POSTINC: begin
        effAddr = accPtr;
        ptrNew  = accPtr + 16'h0001;
        ptrUpd  = 1'b1;
      end
    endcase
    // Six-bit port number can never leave standard I/O
    if (accPortIo) begin
      effAddr = REGFILE_END + {10'h000, accAddr[5:0]};
    end
    ioOff      = effAddr - REGFILE_END;
    takeRegion = dsdDecode(effAddr, compat_reg);
    extEn      = cpuCtrl_reg[EXT_EN_BIT];
    takeExt    = takeRegion == RGN_EXT && extEn;
    extra      = accStack ? EXT_EXTRA_STACK + {1'b0, waitStates, 1'b0}
                          : EXT_EXTRA_BYTE + {2'b00, waitStates};
    take       = accReq && state_reg == SEQ_IDLE && !cpuHalt;
    ioRdata    = (ioAddr_reg == IO_CPU_CTRL) ? cpuCtrl_reg : nvRdata;
  end

  // ----------------------------------------------------------------
  // Access sequencer
  // ----------------------------------------------------------------
  always_comb begin
    state_next     = state_reg;
    cnt_next       = cnt_reg;
    strobeLen_next = strobeLen_reg;
    isExt_next     = isExt_reg;
    write_next     = write_reg;
    compat_next    = rst ? compatMode : compat_reg;
    cpuCtrl_next   = cpuCtrl_reg;
    ioAddr_next    = ioAddr_reg;
    ioWr_next      = 1'b0;
    ioWd_next      = ioWd_reg;
    accDone_next   = 1'b0;
    accRdata_next  = accRdata;
    accRegion_next = accRegion;
    ptrWrEn_next   = 1'b0;
    ptrWrSel_next  = ptrWrSel;
    ptrWrData_next = ptrWrData;
    extAddr_next   = extAddr;
    extWdata_next  = extWdata;
    extDataOe_next = extDataOe;
    if (take) begin
      state_next     = SEQ_BUSY;
      cnt_next       = BASE_CYCLES - 4'h1 + (takeExt ? extra : 4'h0);
      strobeLen_next = extra;
      isExt_next     = takeExt;
      write_next     = accWrite;
      accRegion_next = takeRegion;
      ioAddr_next    = ioOff[5:0];
      ptrWrEn_next   = ptrUpd;
      ptrWrSel_next  = accPtrSel;
      ptrWrData_next = ptrNew;
      extAddr_next   = effAddr;
      extWdata_next  = accWdata;
      extDataOe_next = takeExt && accWrite;
      if (takeRegion == RGN_STDIO && accWrite) begin
        ioWr_next = 1'b1;
        ioWd_next = accWdata;
        if (ioOff[5:0] == IO_CPU_CTRL) begin
          cpuCtrl_next = accWdata;
        end
      end
    end else if (state_reg == SEQ_BUSY) begin
      cnt_next = cnt_reg - 4'h1;
      if (cnt_reg == 4'h1) begin
        state_next     = SEQ_IDLE;
        accDone_next   = 1'b1;
        extDataOe_next = 1'b0;
        if (!write_reg) begin
          unique case (accRegion)
            RGN_STDIO: accRdata_next = ioRdata;
            RGN_EXT:   accRdata_next = isExt_reg ? extRdata : 8'h00;
            default:   accRdata_next = intRdata;
          endcase
        end
      end
    end
    // Strobes cover the last strobeLen cycles before done, never internal ones
    extRdN_next   = !(state_next == SEQ_BUSY && isExt_next && !write_next
                      && cnt_next <= strobeLen_next);
    extWrN_next   = !(state_next == SEQ_BUSY && isExt_next && write_next
                      && cnt_next <= strobeLen_next);
    accReady_next = state_next == SEQ_IDLE;
  end

  always_ff @(posedge clock) begin
    compat_reg <= compat_next;
    if (rst) begin
      state_reg       <= SEQ_IDLE;
      cnt_reg         <= 4'h0;
      strobeLen_reg   <= 4'h0;
      isExt_reg       <= 1'b0;
      write_reg       <= 1'b0;
      cpuCtrl_reg     <= CPU_CTRL_RST;
      ioAddr_reg      <= 6'h00;
      ioWr_reg        <= 1'b0;
      ioWd_reg        <= 8'h00;
      accReady        <= 1'b0;
      accDone         <= 1'b0;
      accRdata        <= 8'h00;
      accRegion       <= RGN_REGFILE;
      ptrWrEn         <= 1'b0;
      ptrWrSel        <= 2'h0;
      ptrWrData       <= 16'h0000;
      extAddr         <= 16'h0000;
      extWdata        <= 8'h00;
      extDataOe       <= 1'b0;
      extWriteStrobeN <= 1'b1;
      extReadStrobeN  <= 1'b1;
    end else begin
      state_reg       <= state_next;
      cnt_reg         <= cnt_next;
      strobeLen_reg   <= strobeLen_next;
      isExt_reg       <= isExt_next;
      write_reg       <= write_next;
      cpuCtrl_reg     <= cpuCtrl_next;
      ioAddr_reg      <= ioAddr_next;
      ioWr_reg        <= ioWr_next;
      ioWd_reg        <= ioWd_next;
      accReady        <= accReady_next;
      accDone         <= accDone_next;
      accRdata        <= accRdata_next;
      accRegion       <= accRegion_next;
      ptrWrEn         <= ptrWrEn_next;
      ptrWrSel        <= ptrWrSel_next;
      ptrWrData       <= ptrWrData_next;
      extAddr         <= extAddr_next;
      extWdata        <= extWdata_next;
      extDataOe       <= extDataOe_next;
      extWriteStrobeN <= extWrN_next;
      extReadStrobeN  <= extRdN_next;
    end
  end

  // ----------------------------------------------------------------
  // Non-volatile store port
  // ----------------------------------------------------------------
  dsd_nv_port #(
    .WRITE_CYCLES (NV_WRITE_CYC)
  ) u_nv (
    .clock   (clock),
    .rst     (rst),
    .ioWrEn  (ioWr_reg),
    .ioAddr  (ioAddr_reg),
    .ioWdata (ioWd_reg),
    .ioRdata (nvRdata),
    .cpuHalt (cpuHalt)
  );

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_int_two_cyc: assert property (@(posedge clock) disable iff (rst)
    take && !takeExt |-> ##2 accDone)
    else $error("internal access not done in two cycles");
  a_ext_one_more: assert property (@(posedge clock) disable iff (rst)
    take && takeExt && !accStack && waitStates == 2'h0 |=> !accDone[*2] ##1 accDone)
    else $error("external byte not three cycles");
  a_stack_three: assert property (@(posedge clock) disable iff (rst)
    take && takeExt && accStack && waitStates == 2'h0 |-> ##5 accDone)
    else $error("external stack access not five cycles");
  a_wait_penalty: assert property (@(posedge clock) disable iff (rst)
    take && takeExt && !accStack && waitStates == 2'h3 |-> ##6 accDone)
    else $error("three wait states not six cycles");
  a_stack_wait: assert property (@(posedge clock) disable iff (rst)
    take && takeExt && accStack && waitStates == 2'h1 |-> ##7 accDone)
    else $error("stack with one wait state not seven cycles");
  a_int_no_strobe: assert property (@(posedge clock) disable iff (rst)
    state_reg == SEQ_BUSY && !isExt_reg |-> extReadStrobeN && extWriteStrobeN)
    else $error("strobe active on internal access");
  a_ext_disabled: assert property (@(posedge clock) disable iff (rst)
    take && !extEn |=> !isExt_reg ##1 extReadStrobeN && extWriteStrobeN)
    else $error("external access while disabled");
  a_strobe_len: assert property (@(posedge clock) disable iff (rst)
    take && takeExt && !accWrite && !accStack && waitStates == 2'h2
    |=> extReadStrobeN ##1 !extReadStrobeN[*3] ##1 extReadStrobeN)
    else $error("read strobe width wrong for two wait states");
  a_port_io_std: assert property (@(posedge clock) disable iff (rst)
    take && accPortIo |=> accRegion == RGN_STDIO)
    else $error("port access left standard I/O");
  a_compat_no_xio: assert property (@(posedge clock) disable iff (rst)
    take && compat_reg |=> accRegion != RGN_EXTIO)
    else $error("extended I/O in compatibility map");
  a_norm_sram: assert property (@(posedge clock) disable iff (rst)
    take && !compat_reg && effAddr >= EXTIO_END && effAddr < INT_END_NORMAL |=> accRegion == RGN_INTSRAM)
    else $error("normal map SRAM decode wrong");
  a_above_ext: assert property (@(posedge clock) disable iff (rst)
    take && effAddr >= INT_END_NORMAL |=> accRegion == RGN_EXT)
    else $error("high address not external");
  a_ptr_post: assert property (@(posedge clock) disable iff (rst)
    take && accMode == AM_POSTINC |=> ptrWrEn && ptrWrData == $past(accPtr) + 16'h0001)
    else $error("post-increment write-back wrong");
  a_disp_add: assert property (@(posedge clock) disable iff (rst)
    take && !accPortIo && accMode == AM_DISP && accPtrSel != PTR_X
    |=> extAddr == $past(accPtr) + {10'h000, $past(accDisp)})
    else $error("displacement address wrong");
  a_compat_hold: assert property (@(posedge clock) disable iff (rst)
    !$past(rst) |-> $stable(compat_reg))
    else $error("map mode changed after reset");
  c_ext_write: cover property (@(posedge clock) take && takeExt && accWrite);
  c_ext_stack: cover property (@(posedge clock) take && takeExt && accStack && waitStates == 2'h3);
  c_port_io: cover property (@(posedge clock) take && accPortIo && !accWrite);

endmodule

/* File: hw/dsd_nv_port.sv */
/*
  CPU-side port of the non-volatile data store: address, data and control
  locations, the 4K byte array, write timing and CPU halts.
  Assumes I/O writes arrive as one-cycle strobes from the decoder.
*/
`timescale 1ns/100ps
module dsd_nv_port import dsd_pkg::*; #(
  parameter int WRITE_CYCLES = NV_WRITE_CYCLES
) (
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       rst,
  // I/O location access
  input  wire logic       ioWrEn,
  input  wire logic [5:0] ioAddr,
  input  wire logic [7:0] ioWdata,
  output logic      [7:0] ioRdata,
  // CPU halt
  output logic            cpuHalt
);

  localparam int TW = $clog2(WRITE_CYCLES + 1);

  logic [7:0]           mem [NV_DEPTH];
  logic [NV_ADDR_W-1:0] addr_reg, addr_next;
  logic [7:0]           data_reg, data_next;
  logic [2:0]           mweCnt_reg, mweCnt_next;
  logic                 mwe_reg, mwe_next;
  logic                 ws_reg, ws_next;
  logic [TW-1:0]        timer_reg, timer_next;
  logic [2:0]           halt_reg, halt_next;
  logic                 cpuHalt_next;
  logic                 memWe, wrCtrl, wrStart, rdStart;

  always_comb begin
    wrCtrl      = ioWrEn && ioAddr == IO_NV_CTRL;
    wrStart     = wrCtrl && ioWdata[NV_WS_BIT] && mwe_reg && !ws_reg;
    rdStart     = wrCtrl && ioWdata[NV_RD_BIT] && !ws_reg && !wrStart;
    addr_next   = addr_reg;
    data_next   = data_reg;
    ws_next     = ws_reg;
    timer_next  = timer_reg;
    memWe       = 1'b0;
    mweCnt_next = (mweCnt_reg != 3'h0) ? mweCnt_reg - 3'h1 : mweCnt_reg;
    halt_next   = (halt_reg != 3'h0) ? halt_reg - 3'h1 : halt_reg;
    // Software set beats the timeout in the same cycle
    if (wrCtrl && ioWdata[NV_MWE_BIT]) begin
      mweCnt_next = NV_MWE_WINDOW;
    end
    mwe_next = mweCnt_next != 3'h0;
    // Address is frozen while a write runs
    if (ioWrEn && !ws_reg && ioAddr == IO_NV_ADDR_LO) begin
      addr_next[7:0] = ioWdata;
    end
    if (ioWrEn && !ws_reg && ioAddr == IO_NV_ADDR_HI) begin
      addr_next[NV_ADDR_W-1:8] = ioWdata[NV_ADDR_W-9:0];
    end
    if (ioWrEn && ioAddr == IO_NV_DATA) begin
      data_next = ioWdata;
    end
    if (ws_reg) begin
      timer_next = timer_reg - TW'(1);
      if (timer_reg == TW'(1)) begin
        ws_next = 1'b0;
      end
    end
    if (wrStart) begin
      memWe      = 1'b1;
      ws_next    = 1'b1;
      timer_next = TW'(WRITE_CYCLES);
      halt_next  = NV_WR_HALT;
    end
    if (rdStart) begin
      data_next = mem[addr_reg];
      halt_next = NV_RD_HALT;
    end
    cpuHalt_next = halt_next != 3'h0;
    unique case (ioAddr)
      IO_NV_CTRL:    ioRdata = {5'h00, mwe_reg, ws_reg, 1'b0};
      IO_NV_DATA:    ioRdata = data_reg;
      IO_NV_ADDR_LO: ioRdata = addr_reg[7:0];
      IO_NV_ADDR_HI: ioRdata = {4'h0, addr_reg[NV_ADDR_W-1:8]};
      default:       ioRdata = 8'h00;
    endcase
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      addr_reg   <= '0;
      data_reg   <= 8'h00;
      mweCnt_reg <= 3'h0;
      mwe_reg    <= 1'b0;
      ws_reg     <= 1'b0;
      timer_reg  <= '0;
      halt_reg   <= 3'h0;
      cpuHalt    <= 1'b0;
    end else begin
      addr_reg   <= addr_next;
      data_reg   <= data_next;
      mweCnt_reg <= mweCnt_next;
      mwe_reg    <= mwe_next;
      ws_reg     <= ws_next;
      timer_reg  <= timer_next;
      halt_reg   <= halt_next;
      cpuHalt    <= cpuHalt_next;
    end
  end

  // Array has no reset
  always_ff @(posedge clock) begin
    if (memWe) begin
      mem[addr_reg] <= data_reg;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  a_read_halt4: assert property (rdStart |=> cpuHalt[*4] ##1 !cpuHalt)
    else $error("read halt is not four cycles");
  a_write_halt2: assert property (wrStart |=> cpuHalt[*2] ##1 !cpuHalt)
    else $error("write halt is not two cycles");
  a_no_mwe_ignored: assert property (wrCtrl && ioWdata[NV_WS_BIT] && !mwe_reg && !ws_reg |=> !ws_reg)
    else $error("write started without master enable");
  a_strobe_auto_clr: assert property ($fell(ws_reg) |-> $past(timer_reg) == TW'(1))
    else $error("write strobe cleared before write time");
  a_addr_frozen: assert property (ws_reg |=> $stable(addr_reg))
    else $error("address changed during write");
  a_hi_reads_zero: assert property (ioAddr == IO_NV_ADDR_HI |-> ioRdata[7:4] == 4'h0)
    else $error("reserved address bits not zero");
  c_nv_write: cover property (wrStart ##1 ws_reg);
  c_nv_read: cover property (rdStart ##5 !cpuHalt);

endmodule

/* File: hw/dsd_pkg.sv */
/*
  Shared constants, types and the address decode function for the data-space
  decoder and its non-volatile store port.
  Assumes one 10 MHz CPU clock and a synchronous active-high reset.
*/
package dsd_pkg;

  // ----------------------------------------------------------------
  // Data space map
  // ----------------------------------------------------------------
  localparam logic [15:0] REGFILE_END    = 16'h0020;
  localparam logic [15:0] STDIO_END      = 16'h0060;
  localparam logic [15:0] EXTIO_END      = 16'h0100;
  localparam logic [15:0] INT_END_NORMAL = 16'h1100;
  localparam logic [15:0] INT_END_COMPAT = 16'h1000;

  // ----------------------------------------------------------------
  // Standard I/O locations and fields
  // ----------------------------------------------------------------
  localparam logic [5:0] IO_NV_CTRL    = 6'h1C;
  localparam logic [5:0] IO_NV_DATA    = 6'h1D;
  localparam logic [5:0] IO_NV_ADDR_LO = 6'h1E;
  localparam logic [5:0] IO_NV_ADDR_HI = 6'h1F;
  localparam logic [5:0] IO_CPU_CTRL   = 6'h35;
  localparam int         EXT_EN_BIT    = 7;
  localparam int         NV_RD_BIT     = 0;
  localparam int         NV_WS_BIT     = 1;
  localparam int         NV_MWE_BIT    = 2;
  localparam logic [7:0] CPU_CTRL_RST  = 8'h00;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam logic [3:0] BASE_CYCLES     = 4'h2;
  localparam logic [3:0] EXT_EXTRA_BYTE  = 4'h1;
  localparam logic [3:0] EXT_EXTRA_STACK = 4'h3;
  localparam logic [2:0] NV_MWE_WINDOW   = 3'h4;
  localparam logic [2:0] NV_RD_HALT      = 3'h4;
  localparam logic [2:0] NV_WR_HALT      = 3'h2;
  localparam int         CLOCK_HZ        = 10_000_000;
  localparam int         NV_WRITE_US     = 8500;
  localparam int         NV_WRITE_CYCLES = NV_WRITE_US * (CLOCK_HZ / 1_000_000);
  localparam int         NV_ADDR_W       = 12;
  localparam int         NV_DEPTH        = 4096;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {RGN_REGFILE, RGN_STDIO, RGN_EXTIO, RGN_INTSRAM, RGN_EXT} dsd_region_e;
  typedef enum logic [2:0] {AM_DIRECT, AM_INDIRECT, AM_DISP, AM_PREDEC, AM_POSTINC} dsd_mode_e;
  localparam logic [1:0] PTR_X = 2'h0;

  function automatic dsd_region_e dsdDecode(input logic [15:0] addr, input logic compat);
    dsd_region_e r;
    if (addr < REGFILE_END) r = RGN_REGFILE;
    else if (addr < STDIO_END) r = RGN_STDIO;
    else if (!compat && addr < EXTIO_END) r = RGN_EXTIO;
    else if (addr < (compat ? INT_END_COMPAT : INT_END_NORMAL)) r = RGN_INTSRAM;
    else r = RGN_EXT;
    return r;
  endfunction

endpackage

/* File: tb/data_space_decoder_eeprom_port_bench.sv */
/*
  Self-checking bench for the data-space decoder and non-volatile port.
  Assumes the package and the SRAM model are compiled first.
*/
`timescale 1ns/100ps
module data_space_decoder_eeprom_port_bench import dsd_pkg::*;;
  logic        clock = 1'b0, rst = 1'b1, compatMode = 1'b0, accReq = 1'b0, accWrite = 1'b0;
  logic        accPortIo = 1'b0, accStack = 1'b0, accReady, accDone, cpuHalt, ptrWrEn;
  logic        extDataOe, extWriteStrobeN, extReadStrobeN;
  logic [1:0]  waitStates = 2'h0, accPtrSel = 2'h2, ptrWrSel;
  logic [15:0] accAddr = 16'h0000, accPtr = 16'h0000, ptrWrData, extAddr, pw;
  logic [5:0]  accDisp = 6'h3F;
  logic [7:0]  accWdata = 8'h00, accRdata, extWdata, extRdata, rd;
  dsd_mode_e   accMode = AM_DIRECT;
  dsd_region_e accRegion;
  int          failures = 0, n_checks = 0, n, sl, hc;
  wire  [7:0]  intRdata = ~accAddr[7:0];

  always #50 clock = ~clock;

  dsd_decoder #(.NV_WRITE_CYC(20)) dut (.clock(clock), .rst(rst), .compatMode(compatMode),
    .waitStates(waitStates), .accReq(accReq), .accWrite(accWrite), .accPortIo(accPortIo), .accStack(accStack),
    .accMode(accMode), .accAddr(accAddr), .accPtrSel(accPtrSel), .accPtr(accPtr), .accDisp(accDisp),
    .accWdata(accWdata), .intRdata(intRdata), .accReady(accReady), .accDone(accDone), .accRdata(accRdata),
    .accRegion(accRegion), .cpuHalt(cpuHalt), .ptrWrEn(ptrWrEn), .ptrWrSel(ptrWrSel), .ptrWrData(ptrWrData),
    .extAddr(extAddr), .extWdata(extWdata), .extDataOe(extDataOe), .extRdata(extRdata),
    .extWriteStrobeN(extWriteStrobeN), .extReadStrobeN(extReadStrobeN));
  dsd_sram_model sram (.clock(clock), .addr(extAddr), .wdata(extWdata), .dataOe(extDataOe),
    .writeN(extWriteStrobeN), .readN(extReadStrobeN), .rdata(extRdata));

  // --------------------------------------------------------------
  // Shared tasks
  // --------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks=%0d mismatches=%0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic do_reset(input logic c);
    rst = 1'b1;
    compatMode = c;
    repeat (8) @(negedge clock);
    rst = 1'b0;
    repeat (2) @(negedge clock);
  endtask
  // Called at a falling edge; n is the done cycle counted from the take edge
  task automatic acc(input logic w, p, s, input dsd_mode_e m, input logic [15:0] a, input logic [1:0] ws,
                     input logic [7:0] d);
    accWrite = w;
    accPortIo = p;
    accStack = s;
    accMode = m;
    accAddr = a;
    waitStates = ws;
    accWdata = d;
    accReq = 1'b1;
    while (!(accReady === 1'b1 && cpuHalt === 1'b0)) @(negedge clock);
    @(negedge clock);
    accReq = 1'b0;
    n = 1;
    sl = 0;
    pw = 16'hFFFF;
    while (accDone !== 1'b1 && n < 40) begin
      if (extReadStrobeN === 1'b0 || extWriteStrobeN === 1'b0) sl++;
      if (ptrWrEn === 1'b1) pw = ptrWrData;
      @(negedge clock);
      n++;
    end
    rd = accRdata;
  endtask
  task automatic halts;
    hc = 0;
    repeat (6) begin
      if (cpuHalt === 1'b1) hc++;
      @(negedge clock);
    end
  endtask

  // --------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------
  task automatic t_map(input logic c);
    logic [15:0] an [5] = '{16'h005F, 16'h0060, 16'h00FF, 16'h10FF, 16'h1100};
    dsd_region_e rn [5] = '{RGN_STDIO, RGN_EXTIO, RGN_EXTIO, RGN_INTSRAM, RGN_EXT};
    dsd_region_e rc [5] = '{RGN_STDIO, RGN_INTSRAM, RGN_INTSRAM, RGN_EXT, RGN_EXT};
    do_reset(c);
    foreach (an[i]) begin
      acc(1'b0, 1'b0, 1'b0, AM_DIRECT, an[i], 2'h0, 8'h00);
      chk(16'(accRegion), 16'(c ? rc[i] : rn[i]));
      chk(16'(n), 16'h0002);
      chk(16'(sl), 16'h0000);
      chk(16'(rd), (i == 1) ? 16'h009F : 16'h0000);
    end
    acc(1'b0, 1'b1, 1'b0, AM_DIRECT, 16'hFFFF, 2'h0, 8'h00);
    chk(16'(accRegion), 16'(RGN_STDIO));
    $display("map test done");
  endtask
  task automatic t_ptr;
    accPtr = 16'h01FF;
    acc(1'b0, 1'b0, 1'b0, AM_POSTINC, 16'h0000, 2'h0, 8'h00);
    chk(pw, 16'h0200);
    chk(16'(ptrWrSel), 16'h0002);
    acc(1'b0, 1'b0, 1'b0, AM_PREDEC, 16'h0000, 2'h0, 8'h00);
    chk(pw, 16'h01FE);
    acc(1'b0, 1'b0, 1'b0, AM_DISP, 16'h0000, 2'h0, 8'h00);
    chk(extAddr, 16'h023E);
    $display("pointer test done");
  endtask
  task automatic t_ext;
    acc(1'b1, 1'b1, 1'b0, AM_DIRECT, 16'h0035, 2'h0, 8'h80);
    acc(1'b1, 1'b0, 1'b0, AM_DIRECT, 16'h2000, 2'h0, 8'h5A);
    for (int w = 0; w < 4; w++) begin
      acc(1'b0, 1'b0, 1'b0, AM_DIRECT, 16'h2000, 2'(w), 8'h00);
      chk(16'(n), 16'(3 + w));
      chk(16'(sl), 16'(1 + w));
      chk(16'(rd), 16'h005A);
      acc(1'b0, 1'b0, 1'b1, AM_DIRECT, 16'hF000, 2'(w), 8'h00);
      chk(16'(n), 16'(5 + 2 * w));
    end
    $display("external test done");
  endtask
  task automatic t_nv;
    acc(1'b1, 1'b1, 1'b0, AM_DIRECT, 16'h001F, 2'h0, 8'hFF);
    acc(1'b0, 1'b1, 1'b0, AM_DIRECT, 16'h001F, 2'h0, 8'h00);
    chk(16'(rd), 16'h000F);
    acc(1'b1, 1'b1, 1'b0, AM_DIRECT, 16'h001C, 2'h0, 8'h01);
    halts();
    chk(16'(hc), 16'h0004);
    acc(1'b1, 1'b1, 1'b0, AM_DIRECT, 16'h001C, 2'h0, 8'h02);
    halts();
    chk(16'(hc), 16'h0000);
    acc(1'b1, 1'b1, 1'b0, AM_DIRECT, 16'h001C, 2'h0, 8'h04);
    acc(1'b1, 1'b1, 1'b0, AM_DIRECT, 16'h001C, 2'h0, 8'h02);
    halts();
    chk(16'(hc), 16'h0002);
    acc(1'b0, 1'b1, 1'b0, AM_DIRECT, 16'h001C, 2'h0, 8'h00);
    chk(16'(rd[1]), 16'h0001);
    acc(1'b1, 1'b1, 1'b0, AM_DIRECT, 16'h001F, 2'h0, 8'h00);
    repeat (25) @(negedge clock);
    acc(1'b0, 1'b1, 1'b0, AM_DIRECT, 16'h001F, 2'h0, 8'h00);
    chk(16'(rd), 16'h000F);
    acc(1'b0, 1'b1, 1'b0, AM_DIRECT, 16'h001C, 2'h0, 8'h00);
    chk(16'(rd[1]), 16'h0000);
    $display("store test done");
  endtask

  initial begin
    t_map(1'b0);
    t_ptr();
    t_ext();
    t_nv();
    t_map(1'b1);
    tally_and_finish();
  end
  // Whole run needs well under 1000 cycles; allow 3000 before declaring a hang
  initial begin
    #300000;
    failures++;
    tally_and_finish();
  end
endmodule

/* File: tb/dsd_sram_model.sv */
/*
  Asynchronous external SRAM seen by the decoder's strobes.
  Assumes active-low strobes that are timed from the bench clock.
*/
`timescale 1ns/100ps
module dsd_sram_model (
  // SRAM bus
  input  wire logic        clock,
  input  wire logic [15:0] addr,
  input  wire logic [7:0]  wdata,
  input  wire logic        dataOe,
  input  wire logic        writeN,
  input  wire logic        readN,
  output logic      [7:0]  rdata
);
  logic [7:0] mem [0:255];
  logic [7:0] lastQ = 8'h00;
  // Released bus shows the inverse of the last byte so stale data never matches
  assign rdata = (readN === 1'b0) ? mem[addr[7:0]] : ~lastQ;
  always @(posedge clock) begin
    if (readN === 1'b0) lastQ <= mem[addr[7:0]];
    if (writeN === 1'b0 && dataOe === 1'b1) mem[addr[7:0]] <= wdata;
  end
endmodule
